// File: verilog/can_acceptance_mask_pkg.sv
// can_acceptance_mask_pkg: offsets, field positions and widths of the mask stage
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register
package can_acceptance_mask_pkg;
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  OFS_MASK_STD    = 4'h0;
	localparam logic [3:0]  OFS_MASK_EXT    = 4'h4;
	localparam logic [3:0]  OFS_MATCH_STAT  = 4'h8;
	localparam int          STD_FIELD_LSB   = 5;
	localparam int          MODE_BIT_POS    = 3;
	localparam int          STD_ID_W        = 11;
	localparam int          EXT_ID_W        = 18;
	localparam logic [15:0] STD_WRITE_MASK  = 16'hFFEB;
	localparam logic [15:0] MASK_RESET_VAL  = 16'h0000;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// File: verilog/can_acceptance_mask.sv
// can_acceptance_mask: mask registers and the masked filter comparison
// assumes an AXI4-Lite master on i_clk and a protocol engine presenting ids on i_clk
// How it works
// - standard mask sits in bits 15:5; one compares the bit, zero ignores it
// - mode bit 3 set: frame type must equal the filter's extended select
// - extended mask bits 17:16 and 15:0 include or ignore identifier bits
// - second mask word holds all sixteen low extended mask bits, writable
// - first word: bits 4 and 2 unimplemented and read as zero
`timescale 1ns/10ps
`default_nettype none
module can_acceptance_mask
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [3:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [3:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	input  wire logic        i_msg_valid,
	input  wire logic [10:0] i_msg_std_id,
	input  wire logic [17:0] i_msg_ext_id,
	input  wire logic        i_msg_is_ext,
	input  wire logic [10:0] i_filt_std_id,
	input  wire logic [17:0] i_filt_ext_id,
	input  wire logic        i_filt_extended_frame_select,
	output logic             o_match_valid,
	output logic             o_match
);
	logic [15:0] accept_mask_std_id_q, accept_mask_std_id_d;
	logic [15:0] accept_mask_ext_id_q, accept_mask_ext_id_d;
	logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [3:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        match_valid_q, match_valid_d, match_q, match_d;
	logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic        aw_take, w_take, do_write, ar_take;
	logic [3:0]  waddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic [15:0] wmerge_std, wmerge_ext;
	logic [10:0] std_ident_mask_bits;
	logic [17:0] ext_ident_mask_bits;
	logic        frame_type_match_mode;
	logic        std_ok, ext_ok, type_ok;

	// mask fields picked out of the two words
	assign std_ident_mask_bits   = accept_mask_std_id_q[15:5];
	assign frame_type_match_mode = accept_mask_std_id_q[can_acceptance_mask_pkg::MODE_BIT_POS];
	assign ext_ident_mask_bits   = {accept_mask_std_id_q[1:0], accept_mask_ext_id_q};

	// bus handshakes; address and data may come in either order
	assign aw_take  = i_s_axi_awvalid && !aw_hold_q && !bvalid_q;
	assign w_take   = i_s_axi_wvalid && !w_hold_q && !bvalid_q;
	assign waddr    = aw_hold_q ? awaddr_q : i_s_axi_awaddr;
	assign wdata    = w_hold_q ? wdata_q : i_s_axi_wdata;
	assign wstrb    = w_hold_q ? wstrb_q : i_s_axi_wstrb;
	assign do_write = (aw_hold_q || aw_take) && (w_hold_q || w_take);
	assign ar_take  = i_s_axi_arvalid && !rvalid_q;

	// byte-lane merge of write data
	always_comb
	begin
		wmerge_std = accept_mask_std_id_q;
		wmerge_ext = accept_mask_ext_id_q;
		if (wstrb[0])
		begin
			wmerge_std[7:0] = wdata[7:0];
			wmerge_ext[7:0] = wdata[7:0];
		end
		if (wstrb[1])
		begin
			wmerge_std[15:8] = wdata[15:8];
			wmerge_ext[15:8] = wdata[15:8];
		end
		wmerge_std = wmerge_std & can_acceptance_mask_pkg::STD_WRITE_MASK;
	end

	// register file and bus next state
	always_comb
	begin
		accept_mask_std_id_d = accept_mask_std_id_q;
		accept_mask_ext_id_d = accept_mask_ext_id_q;
		aw_hold_d = aw_hold_q;
		w_hold_d  = w_hold_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q && !i_s_axi_bready;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q && !i_s_axi_rready;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		if (do_write)
		begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = can_acceptance_mask_pkg::RESP_OKAY;
			unique case (waddr)
				can_acceptance_mask_pkg::OFS_MASK_STD: accept_mask_std_id_d = wmerge_std;
				can_acceptance_mask_pkg::OFS_MASK_EXT: accept_mask_ext_id_d = wmerge_ext;
				can_acceptance_mask_pkg::OFS_MATCH_STAT: bresp_d = can_acceptance_mask_pkg::RESP_OKAY;
				default: bresp_d = can_acceptance_mask_pkg::RESP_SLVERR;
			endcase
		end
		else
		begin
			if (aw_take)
			begin
				aw_hold_d = 1'b1;
				awaddr_d  = i_s_axi_awaddr;
			end
			if (w_take)
			begin
				w_hold_d = 1'b1;
				wdata_d  = i_s_axi_wdata;
				wstrb_d  = i_s_axi_wstrb;
			end
		end
		if (ar_take)
		begin
			rvalid_d = 1'b1;
			rresp_d  = can_acceptance_mask_pkg::RESP_OKAY;
			unique case (i_s_axi_araddr)
				can_acceptance_mask_pkg::OFS_MASK_STD: rdata_d = {16'h0000, accept_mask_std_id_q};
				can_acceptance_mask_pkg::OFS_MASK_EXT: rdata_d = {16'h0000, accept_mask_ext_id_q};
				can_acceptance_mask_pkg::OFS_MATCH_STAT: rdata_d = {30'h0, match_q, match_valid_q};
				default:
				begin
					rdata_d = 32'h00000000;
					rresp_d = can_acceptance_mask_pkg::RESP_SLVERR;
				end
			endcase
		end
		// readies registered so every bus output leaves a flop
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d  = !w_hold_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	// masked identifier comparison and frame-type rule
	always_comb
	begin
		std_ok  = ((i_msg_std_id ^ i_filt_std_id) & std_ident_mask_bits) == 11'h000;
		ext_ok  = ((i_msg_ext_id ^ i_filt_ext_id) & ext_ident_mask_bits) == 18'h00000;
		type_ok = frame_type_match_mode ? (i_msg_is_ext == i_filt_extended_frame_select)
		                                : 1'b1;
		match_valid_d = i_msg_valid;
		match_d       = i_msg_valid && type_ok && std_ok && (!i_msg_is_ext || ext_ok);
	end

	// registers; masks come up cleared, every bit is don't-care until written
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			accept_mask_std_id_q <= can_acceptance_mask_pkg::MASK_RESET_VAL;
			accept_mask_ext_id_q <= can_acceptance_mask_pkg::MASK_RESET_VAL;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			bvalid_q      <= 1'b0;
			bresp_q       <= 2'h0;
			rvalid_q      <= 1'b0;
			rresp_q       <= 2'h0;
			rdata_q       <= 32'h00000000;
			match_valid_q <= 1'b0;
			match_q       <= 1'b0;
			awready_q     <= 1'b1;
			wready_q      <= 1'b1;
			arready_q     <= 1'b1;
		end
		else
		begin
			accept_mask_std_id_q <= accept_mask_std_id_d;
			accept_mask_ext_id_q <= accept_mask_ext_id_d;
			aw_hold_q     <= aw_hold_d;
			w_hold_q      <= w_hold_d;
			awaddr_q      <= awaddr_d;
			wdata_q       <= wdata_d;
			wstrb_q       <= wstrb_d;
			bvalid_q      <= bvalid_d;
			bresp_q       <= bresp_d;
			rvalid_q      <= rvalid_d;
			rresp_q       <= rresp_d;
			rdata_q       <= rdata_d;
			match_valid_q <= match_valid_d;
			match_q       <= match_d;
			awready_q     <= awready_d;
			wready_q      <= wready_d;
			arready_q     <= arready_d;
		end
	end

	assign o_s_axi_awready = awready_q;
	assign o_s_axi_wready  = wready_q;
	assign o_s_axi_bvalid  = bvalid_q;
	assign o_s_axi_bresp   = bresp_q;
	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid  = rvalid_q;
	assign o_s_axi_rdata   = rdata_q;
	assign o_s_axi_rresp   = rresp_q;
	assign o_match_valid   = match_valid_q;
	assign o_match         = match_q;

	// checks
	a_unimpl_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		accept_mask_std_id_q[4] == 1'b0 && accept_mask_std_id_q[2] == 1'b0)
		else $error("unimplemented mask bits set");
	a_type_strict: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_msg_valid && frame_type_match_mode && (i_msg_is_ext != i_filt_extended_frame_select))
		|=> !o_match)
		else $error("frame type mismatch accepted");
	a_std_dontcare: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_msg_valid && !frame_type_match_mode && !i_msg_is_ext && std_ident_mask_bits == 11'h000)
		|=> o_match)
		else $error("zero mask did not match");
	a_mixed_accept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_msg_valid && !frame_type_match_mode && i_msg_is_ext && (i_msg_std_id == i_filt_std_id)
		 && (i_msg_ext_id == i_filt_ext_id)) |=> o_match)
		else $error("equal ids rejected in mixed mode");
	a_ext_bit_used: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_msg_valid && i_msg_is_ext && ((i_msg_ext_id ^ i_filt_ext_id) & ext_ident_mask_bits) != 18'h00000)
		|=> !o_match)
		else $error("masked extended difference accepted");
	a_std_bit_used: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_msg_valid && ((i_msg_std_id ^ i_filt_std_id) & std_ident_mask_bits) != 11'h000)
		|=> !o_match)
		else $error("masked standard difference accepted");
	a_ext_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(do_write && waddr == can_acceptance_mask_pkg::OFS_MASK_EXT && wstrb[1:0] == 2'h3)
		|=> accept_mask_ext_id_q == $past(wdata[15:0]))
		else $error("extended mask word not written");
	a_match_needs_valid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_match |-> o_match_valid && $past(i_msg_valid))
		else $error("match without message");
	a_bresp_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		do_write |=> o_s_axi_bvalid)
		else $error("write response missing");
	c_strict_mode: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_msg_valid && frame_type_match_mode ##1 o_match);
	c_mixed_mode: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_msg_valid && !frame_type_match_mode && i_msg_is_ext ##1 o_match);
	c_reject: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		o_match_valid && !o_match);
endmodule
`default_nettype wire

// File: sim/can_msg_source.sv
// can_msg_source: stand-in protocol engine handing received ids over
// assumes the consumer samples on the rising edge of i_clk
`timescale 1ns/10ps
`default_nettype none
module can_msg_source
(
	input  wire logic        i_clk,
	output logic             o_msg_valid,
	output logic [10:0]      o_std_id,
	output logic [17:0]      o_ext_id,
	output logic             o_is_ext
);
	// quiet before the first frame
	initial
	begin
		o_msg_valid = 1'b0;
		o_std_id = 11'h000;
		o_ext_id = 18'h00000;
		o_is_ext = 1'b0;
	end
	// one message for one edge per call
	task automatic send(input logic [10:0] s, input logic [17:0] e, input logic x);
		@(posedge i_clk);
		o_msg_valid <= 1'b1;
		o_std_id <= s;
		o_ext_id <= e;
		o_is_ext <= x;
	endtask
	// ids flip when idle so stale values never pass
	task automatic idle();
		@(posedge i_clk);
		o_msg_valid <= 1'b0;
		o_std_id <= ~o_std_id;
		o_ext_id <= ~o_ext_id;
		o_is_ext <= ~o_is_ext;
	endtask
endmodule
`default_nettype wire

// File: sim/can_acceptance_mask_bench.sv
// can_acceptance_mask_bench: mask registers over the bus, then id matching
// assumes the mask block and can_msg_source are compiled first
`timescale 1ns/10ps
`default_nettype none
module can_acceptance_mask_bench;
	localparam logic [3:0] STD = can_acceptance_mask_pkg::OFS_MASK_STD;
	localparam logic [3:0] EXT = can_acceptance_mask_pkg::OFS_MASK_EXT;
	// row: masks, std ids (message, filter), ext ids (message, filter), flags {is_ext, select, expected}
	typedef struct packed {logic [15:0] sm; logic [15:0] em; logic [10:0] ms; logic [10:0] fs;
		logic [17:0] me; logic [17:0] fe; logic [2:0] fl;} row_type;
	logic        i_clk = 1'b0, i_rst_n = 1'b0, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
	logic        i_s_axi_arvalid = 1'b0, i_s_axi_bready = 1'b1, i_s_axi_rready = 1'b1;
	logic        i_filt_extended_frame_select = 1'b0, i_msg_valid, i_msg_is_ext, o_match;
	logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
	logic        o_s_axi_rvalid, o_match_valid, ta, tw, tr, tb;
	logic [3:0]  i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'h3;
	logic [31:0] i_s_axi_wdata = 32'h00000000, o_s_axi_rdata, rd;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, resp;
	logic [10:0] i_msg_std_id, i_filt_std_id = 11'h000;
	logic [17:0] i_msg_ext_id, i_filt_ext_id = 18'h00000;
	int          failures = 0, samples_checked = 0, cyc = 0;
	row_type     rows [10] = '{
		'{16'hFFE3, 16'hFFFF, 11'h123, 11'h123, 18'h3FFFF, 18'h00000, 3'h1},
		'{16'hFFE0, 16'h0000, 11'h123, 11'h122, 18'h00000, 18'h00000, 3'h0},
		'{16'hFFC0, 16'h0000, 11'h123, 11'h122, 18'h00000, 18'h00000, 3'h1},
		'{16'hFFFF, 16'h0000, 11'h123, 11'h123, 18'h00000, 18'h00000, 3'h2},
		'{16'hFFE8, 16'h0000, 11'h123, 11'h123, 18'h3FFFF, 18'h00000, 3'h7},
		'{16'hFFE8, 16'h0000, 11'h123, 11'h123, 18'h00000, 18'h00000, 3'h4},
		'{16'hFFE0, 16'h0000, 11'h123, 11'h123, 18'h00000, 18'h00000, 3'h5},
		'{16'hFFE3, 16'hFFFF, 11'h123, 11'h123, 18'h3FFFF, 18'h1FFFF, 3'h4},
		'{16'hFFE1, 16'hFFFF, 11'h123, 11'h123, 18'h3FFFF, 18'h1FFFF, 3'h5},
		'{16'hFFE3, 16'hFFFE, 11'h123, 11'h123, 18'h00001, 18'h00000, 3'h5}};

	can_acceptance_mask DUT (.i_clk, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
		.o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
		.o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_msg_valid,
		.i_msg_std_id, .i_msg_ext_id, .i_msg_is_ext, .i_filt_std_id, .i_filt_ext_id,
		.i_filt_extended_frame_select, .o_match_valid, .o_match);
	can_msg_source src (.i_clk, .o_msg_valid(i_msg_valid), .o_std_id(i_msg_std_id),
		.o_ext_id(i_msg_ext_id), .o_is_ext(i_msg_is_ext));

	// 10 MHz clock
	initial
	begin
		forever #50 i_clk = ~i_clk;
	end
	// hang guard
	always @(posedge i_clk)
	begin
		cyc = cyc + 1;
		if (cyc > 5000)
		begin
			failures = failures + 1;
			wrap_up();
		end
	end
	// compare and report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked = samples_checked + 1;
		if (s !== e)
		begin
			failures = failures + 1;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one bus write (w high) or read; ready sampled at the negedge before the taking edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_araddr <= a;
		i_s_axi_wdata <= {16'h0000, d};
		i_s_axi_awvalid <= w;
		i_s_axi_wvalid <= w;
		i_s_axi_arvalid <= !w;
		do
		begin
			@(negedge i_clk);
			ta = i_s_axi_awvalid && o_s_axi_awready;
			tw = i_s_axi_wvalid && o_s_axi_wready;
			tr = i_s_axi_arvalid && o_s_axi_arready;
			tb = w ? o_s_axi_bvalid : o_s_axi_rvalid;
			resp = w ? o_s_axi_bresp : o_s_axi_rresp;
			rd = o_s_axi_rdata;
			@(posedge i_clk);
			if (ta) i_s_axi_awvalid <= 1'b0;
			if (tw) i_s_axi_wvalid <= 1'b0;
			if (tr) i_s_axi_arvalid <= 1'b0;
		end while (!tb);
	endtask
	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// table rows, then pair, unmapped and reset cases
	initial
	begin
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		foreach (rows[i])
		begin
			bus(1'b1, STD, rows[i].sm);
			bus(1'b1, EXT, rows[i].em);
			chk("ext bresp", 32'h0, {30'h0, resp});
			bus(1'b0, STD, 16'h0000);
			chk("std mask", {16'h0000, rows[i].sm & 16'hFFEB}, rd);
			bus(1'b0, EXT, 16'h0000);
			chk("ext mask", {16'h0000, rows[i].em}, rd);
			i_filt_std_id <= rows[i].fs;
			i_filt_ext_id <= rows[i].fe;
			i_filt_extended_frame_select <= rows[i].fl[1];
			src.send(rows[i].ms, rows[i].me, rows[i].fl[2]);
			src.idle();
			@(negedge i_clk);
			chk("match", {30'h0, 1'b1, rows[i].fl[0]}, {30'h0, o_match_valid, o_match});
		end
		src.send(11'h123, 18'h00002, 1'b1);
		src.send(11'h123, 18'h00001, 1'b1);
		@(negedge i_clk);
		chk("first of pair", 32'h2, {30'h0, o_match_valid, o_match});
		src.idle();
		@(negedge i_clk);
		chk("second of pair", 32'h3, {30'h0, o_match_valid, o_match});
		bus(1'b0, can_acceptance_mask_pkg::OFS_MATCH_STAT, 16'h0000);
		chk("status rresp", 32'h0, {30'h0, resp});
		chk("status rdata", 32'h0, rd);
		bus(1'b0, 4'hC, 16'h0000);
		chk("unmapped rresp", 32'h2, {30'h0, resp});
		chk("unmapped rdata", 32'h0, rd);
		bus(1'b1, 4'hC, 16'hFFFF);
		chk("unmapped bresp", 32'h2, {30'h0, resp});
		i_rst_n <= 1'b0;
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		chk("readies", 32'h7, {29'h0, o_s_axi_awready, o_s_axi_wready, o_s_axi_arready});
		bus(1'b0, STD, 16'h0000);
		chk("std after reset", 32'h0, rd);
		bus(1'b0, EXT, 16'h0000);
		chk("ext after reset", 32'h0, rd);
		// low byte lane only: upper byte keeps its reset value
		i_s_axi_wstrb <= 4'h1;
		bus(1'b1, EXT, 16'hA5C3);
		i_s_axi_wstrb <= 4'h3;
		bus(1'b0, EXT, 16'h0000);
		chk("ext low lane", 32'h000000C3, rd);
		wrap_up();
	end
endmodule
`default_nettype wire
